// ==== logic/mri_exec.sv ====
// Functional notes
// - store_acc_to_file writes accumulator to file address 0..127, one cycle, flags kept.
// - load_literal_to_acc puts 8-bit immediate into accumulator, one cycle, flags kept.
// - return_from_irq pops stack, stack_top_entry into PC, two cycles, flags kept.
// - return_from_irq also sets global_irq_enable, bit 7 of irq_control_reg.
// - return_with_literal loads immediate into accumulator and pops PC, two cycles.
// - subroutine return pops stack into PC, two cycles, flags kept.
`timescale 1ns/1ps
`default_nettype none

module mri_exec (
  input  wire logic                        sys_clk,          // instruction clock
  input  wire logic                        reset,            // sync, active high
  input  wire logic [mri_pkg::OP_W-1:0]    instr_word,       // fetched instruction
  input  wire logic                        instr_valid,      // instr_word holds a fetch
  input  wire logic [mri_pkg::PC_W-1:0]    stack_top_entry,  // value on top of stack
  input  wire logic [mri_pkg::DATA_W-1:0]  irq_ctrl_wr_data, // other writers of irq ctrl
  input  wire logic                        irq_ctrl_wr,      // strobe for irq_ctrl_wr_data
  output logic      [mri_pkg::PC_W-1:0]    pc_r,             // program counter
  output logic      [mri_pkg::DATA_W-1:0]  accumulator_reg,  // working accumulator
  output logic      [mri_pkg::DATA_W-1:0]  irq_control_reg,  // interrupt control
  output logic                             stack_pop_r,      // one-cycle pop pulse
  output logic      [mri_pkg::FA_W-1:0]    file_addr_r,      // file write address
  output logic      [mri_pkg::DATA_W-1:0]  file_wdata_r,     // file write data
  output logic                             file_we_r,        // one-cycle file write
  output logic                             busy_r            // second cycle of a return
);
  import mri_pkg::*;

  // ------------------------------------------------------------
  // instruction classes
  // ------------------------------------------------------------
  // one bit per class; words outside the group fall into the
  // no-operation class so the core never stalls on them
  typedef enum logic [5:0] {
    MRI_K_NOP     = 6'h01,
    MRI_K_STORE   = 6'h02,
    MRI_K_LOAD    = 6'h04,
    MRI_K_RET_LIT = 6'h08,
    MRI_K_RET_IRQ = 6'h10,
    MRI_K_RETURN  = 6'h20
  } mri_kind_e;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    mri_state_e           st;
    logic                 busy;
    logic [PC_W-1:0]      pc;
    logic [DATA_W-1:0]    acc;
    logic [DATA_W-1:0]    irq;
    logic                 pop;
    logic [FA_W-1:0]      fa;
    logic [DATA_W-1:0]    fd;
    logic                 we;
  } mri_state_s;

  mri_state_s s_r;
  mri_state_s s_nxt;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [PC_W-1:0] mri_inc(input logic [PC_W-1:0] p);
    mri_inc = PC_W'(p + 13'h0001);
  endfunction

  function automatic logic [DATA_W-1:0] mri_literal(input logic [OP_W-1:0] w);
    mri_literal = w[7:0];
  endfunction

  function automatic logic [FA_W-1:0] mri_file_addr(input logic [OP_W-1:0] w);
    mri_file_addr = w[6:0];
  endfunction

  function automatic mri_kind_e mri_decode(input logic [OP_W-1:0] w);
    mri_kind_e k;
    k = MRI_K_NOP;
    if (w[13:7] == OP_STORE_ACC_HI) begin
      k = MRI_K_STORE;
    end else if (w[13:10] == OP_LOAD_LIT_HI) begin
      k = MRI_K_LOAD;
    end else if (w[13:10] == OP_RET_LIT_HI) begin
      k = MRI_K_RET_LIT;
    end else if (w == OP_RETURN_IRQ) begin
      k = MRI_K_RET_IRQ;
    end else if (w == OP_RETURN) begin
      k = MRI_K_RETURN;
    end else begin
      k = MRI_K_NOP;
    end
    mri_decode = k;
  endfunction

  function automatic logic mri_is_return(input mri_kind_e k);
    mri_is_return = (k == MRI_K_RET_LIT) ||
                    (k == MRI_K_RET_IRQ) ||
                    (k == MRI_K_RETURN);
  endfunction

  // ------------------------------------------------------------
  // issue
  // ------------------------------------------------------------
  // a word offered during the flush slot is the stale prefetch
  // behind a return, so it is never taken
  logic      take;
  mri_kind_e kind;

  assign take = instr_valid && (s_r.st == MRI_ST_EXEC);
  assign kind = mri_decode(instr_word);

  // ------------------------------------------------------------
  // decode and execute
  // ------------------------------------------------------------
  always_comb begin
    s_nxt      = s_r;
    s_nxt.pop  = 1'b0;
    s_nxt.we   = 1'b0;
    s_nxt.busy = 1'b0;
    // a plain write from elsewhere lands first, so a return_from_irq in the
    // same cycle still leaves the enable bit set
    if (irq_ctrl_wr) begin
      s_nxt.irq = irq_ctrl_wr_data;
    end
    case (s_r.st)
      MRI_ST_EXEC: begin
        if (take) begin
          case (kind)
            MRI_K_STORE: begin
              s_nxt.pc = mri_inc(s_r.pc);
              s_nxt.fa = mri_file_addr(instr_word);
              s_nxt.fd = s_r.acc;
              s_nxt.we = 1'b1;
            end
            MRI_K_LOAD: begin
              s_nxt.pc  = mri_inc(s_r.pc);
              s_nxt.acc = mri_literal(instr_word);
            end
            MRI_K_RET_LIT: begin
              s_nxt.acc = mri_literal(instr_word);
              s_nxt.pc  = stack_top_entry;
            end
            MRI_K_RET_IRQ: begin
              s_nxt.pc                     = stack_top_entry;
              s_nxt.irq[GLOBAL_IRQ_EN_BIT] = 1'b1;
            end
            MRI_K_RETURN: begin
              s_nxt.pc = stack_top_entry;
            end
            MRI_K_NOP: begin
              s_nxt.pc = mri_inc(s_r.pc);
            end
            default: begin
              s_nxt.pc = mri_inc(s_r.pc);
            end
          endcase
          // every return pops once and spends one more cycle
          if (mri_is_return(kind)) begin
            s_nxt.pop  = 1'b1;
            s_nxt.busy = 1'b1;
            s_nxt.st   = MRI_ST_FLUSH;
          end
        end
      end
      MRI_ST_FLUSH: begin
        // second cycle of a return: only an irq_ctrl_wr write can change state
        s_nxt.st = MRI_ST_EXEC;
      end
      default: begin
        s_nxt.st = MRI_ST_EXEC;
      end
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_r <= '{st: MRI_ST_EXEC, busy: 1'b0, pc: PC_RESET, acc: ACC_RESET,
               irq: IRQ_CTRL_RESET, pop: 1'b0, fa: 7'h00, fd: 8'h00, we: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // every output is a bare register field, no logic after the flops
  assign pc_r            = s_r.pc;
  assign accumulator_reg = s_r.acc;
  assign irq_control_reg = s_r.irq;
  assign stack_pop_r     = s_r.pop;
  assign file_addr_r     = s_r.fa;
  assign file_wdata_r    = s_r.fd;
  assign file_we_r       = s_r.we;
  assign busy_r          = s_r.busy;

endmodule

`default_nettype wire

// ==== logic/mri_pkg.sv ====
package mri_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int PC_W   = 13;
  localparam int FA_W   = 7;
  localparam int DATA_W = 8;
  localparam int OP_W   = 14;

  // ------------------------------------------------------------
  // opcode encodings (14-bit instruction word)
  // ------------------------------------------------------------
  localparam logic [13:0] OP_NO_OPERATION   = 14'h0000;
  localparam logic [13:0] OP_RETURN         = 14'h0008;
  localparam logic [13:0] OP_RETURN_IRQ     = 14'h0009;
  localparam logic [6:0]  OP_STORE_ACC_HI   = 7'h01;
  localparam logic [3:0]  OP_LOAD_LIT_HI    = 4'hC;
  localparam logic [3:0]  OP_RET_LIT_HI     = 4'hD;

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int          GLOBAL_IRQ_EN_BIT = 7;
  localparam logic [7:0]  ACC_RESET         = 8'h00;
  localparam logic [7:0]  IRQ_CTRL_RESET    = 8'h00;
  localparam logic [12:0] PC_RESET          = 13'h0000;

  // ------------------------------------------------------------
  // sequencer states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MRI_ST_EXEC  = 2'b01,
    MRI_ST_FLUSH = 2'b10
  } mri_state_e;

endpackage

// ==== verification/mri_exec_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module mri_exec_monitor import mri_pkg::*; (
  input wire logic              sys_clk, reset, instr_valid, stack_pop_r, file_we_r, busy_r,
  input wire logic [OP_W-1:0]   instr_word,
  input wire logic [PC_W-1:0]   stack_top_entry, pc_r,
  input wire logic [DATA_W-1:0] accumulator_reg, irq_control_reg, file_wdata_r,
  input wire logic [FA_W-1:0]   file_addr_r
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire logic tk = instr_valid && !busy_r;
  // a return owns its slot and the flush slot behind it
  sequence s_ret; busy_r && stack_pop_r ##1 !busy_r && !stack_pop_r; endsequence
  a_store_write: assert property (tk && instr_word[13:7] == 7'h01 |=> file_we_r &&
    file_addr_r == $past(instr_word[6:0]) && file_wdata_r == $past(accumulator_reg)) else $error("store");
  a_load_acc: assert property (tk && instr_word[13:10] == 4'hC |=>
    accumulator_reg == $past(instr_word[7:0])) else $error("load");
  a_irq_return: assert property (tk && instr_word == 14'h0009 |=>
    pc_r == $past(stack_top_entry) ##0 s_ret) else $error("irq return");
  a_irq_enable: assert property (tk && instr_word == 14'h0009 |=> irq_control_reg[7])
    else $error("irq enable");
  a_lit_return: assert property (tk && instr_word[13:10] == 4'hD |=>
    accumulator_reg == $past(instr_word[7:0]) && pc_r == $past(stack_top_entry) ##0 s_ret) else $error("lit");
  a_sub_return: assert property (tk && instr_word == 14'h0008 |=>
    pc_r == $past(stack_top_entry) ##0 s_ret) else $error("return");
  a_nop_idle: assert property (tk && instr_word == 14'h0000 |=> pc_r == $past(pc_r) + 13'h1 &&
    !stack_pop_r && !file_we_r && $stable(accumulator_reg)) else $error("nop");
  a_flush_quiet: assert property (busy_r |=> !file_we_r && $stable(accumulator_reg))
    else $error("flush");
endmodule
bind mri_exec mri_exec_monitor mri_exec_monitor_i (.*);
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("FAIL %s expected %h seen %h", n, e, g); end end
module testbench;
  import mri_pkg::*;
  logic              sys_clk, reset, instr_valid, irq_ctrl_wr, stack_pop_r, file_we_r, busy_r;
  logic [OP_W-1:0]   instr_word;
  logic [PC_W-1:0]   stack_top_entry, pc_r;
  logic [DATA_W-1:0] irq_ctrl_wr_data, accumulator_reg, irq_control_reg, file_wdata_r;
  logic [FA_W-1:0]   file_addr_r;
  int                fails, check_count;
  mri_exec mri_exec_i (
    .sys_clk(sys_clk), .reset(reset), .instr_word(instr_word), .instr_valid(instr_valid),
    .stack_top_entry(stack_top_entry), .irq_ctrl_wr_data(irq_ctrl_wr_data),
    .irq_ctrl_wr(irq_ctrl_wr), .pc_r(pc_r), .accumulator_reg(accumulator_reg),
    .irq_control_reg(irq_control_reg), .stack_pop_r(stack_pop_r), .file_addr_r(file_addr_r),
    .file_wdata_r(file_wdata_r), .file_we_r(file_we_r), .busy_r(busy_r)
  );
  always #25 sys_clk = ~sys_clk;
  function automatic logic [7:0] acc_of(logic [13:0] w, logic [7:0] a);
    return (w[13:11] == 3'b110) ? w[7:0] : a;
  endfunction
  function automatic logic [13:0] word_of(int k, logic [13:0] r);
    logic [13:0] base[6] = '{14'h0000, 14'h0008, 14'h0009, 14'h0080, 14'h3000, 14'h3400};
    logic [13:0] keep[6] = '{14'h0000, 14'h0000, 14'h0000, 14'h007F, 14'h03FF, 14'h03FF};
    return base[k] | (r & keep[k]);
  endfunction
  task automatic run(logic [13:0] w, logic [12:0] t);
    logic [12:0] p;
    logic [7:0]  a;
    logic        r;
    p = pc_r;
    a = accumulator_reg;
    r = w == 14'h0008 || w == 14'h0009 || w[13:10] == 4'hD;
    instr_word = w;
    stack_top_entry = t;
    @(posedge sys_clk) #1;
    `CHK("acc", acc_of(w, a), accumulator_reg)
    `CHK("pc", r ? t : p + 13'h1, pc_r)
    `CHK("pop", {r, r}, {stack_pop_r, busy_r})
    `CHK("we", w[13:7] == 7'h01, file_we_r)
    if (file_we_r === 1'b1) `CHK("fdata", {a, w[6:0]}, {file_wdata_r, file_addr_r})
    if (w == 14'h0009) `CHK("gie", 1'b1, irq_control_reg[7])
    if (r) begin
      // the word offered in the flush slot must be dropped
      instr_word = word_of($urandom % 6, 14'($urandom));
      @(posedge sys_clk) #1;
      `CHK("flush", {acc_of(w, a), 2'h0, t}, {accumulator_reg, file_we_r, stack_pop_r, pc_r})
    end
  endtask
  task automatic finish_test;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    finish_test;
  end
  initial begin
    sys_clk = 0; reset = 1; instr_valid = 0; instr_word = 0; stack_top_entry = 0;
    irq_ctrl_wr = 0; irq_ctrl_wr_data = 0; fails = 0; check_count = 0;
    void'($urandom(32'h68CC5591));
    repeat (4) @(posedge sys_clk);
    #1 reset = 0;
    irq_ctrl_wr = 1;
    irq_ctrl_wr_data = 8'h3C;
    @(posedge sys_clk) #1 irq_ctrl_wr = 0;
    `CHK("irq", 8'h3C, irq_control_reg)
    instr_valid = 1;
    run(14'h30FF, 13'h0000); run(14'h00FF, 13'h0000); run(14'h0009, 13'h1FFF);
    run(14'h3400, 13'h0000); run(14'h0008, 13'h0AAA); run(14'h0000, 13'h0000);
    `CHK("irq after return", 8'hBC, irq_control_reg)
    irq_ctrl_wr = 1;
    irq_ctrl_wr_data = 8'h00;
    instr_word = 14'h0009;
    stack_top_entry = 13'h0123;
    @(posedge sys_clk) #1 irq_ctrl_wr = 0;
    `CHK("enable wins", 8'h80, irq_control_reg)
    instr_word = 14'h0000;
    @(posedge sys_clk) #1;
    `CHK("pc after collision", 13'h0123, pc_r)
    $display("test corners done");
    repeat (200) run(word_of($urandom % 6, 14'($urandom)), 13'($urandom));
    $display("test random done");
    reset = 1;
    @(posedge sys_clk) #1 reset = 0;
    `CHK("reset", 32'h0, {pc_r, accumulator_reg, irq_control_reg, stack_pop_r, file_we_r, busy_r})
    run(14'h0000, 13'h0000);
    $display("test reset done");
    finish_test;
  end
endmodule
`default_nettype wire
